// >>> rtl/asbp_consts.svh
// Timing and geometry constants for the async SRAM byte port controller
`ifndef ASBP_CONSTS_SVH
`define ASBP_CONSTS_SVH
`define ASBP_ADDR_W 19
`define ASBP_DATA_W 8
`define ASBP_CLK_PERIOD_NS 50
`define ASBP_POWERUP_WAIT_NS 1000
`define ASBP_READ_CYCLE_MIN_NS 25
`define ASBP_SELECT_TO_DATA_VALID_NS 25
`define ASBP_WRITE_PULSE_MIN_NS 15
`define ASBP_WRITE_DATA_SETUP_NS 10
`define ASBP_WRITE_LOW_TO_RELEASE_NS 10
`define ASBP_CNT_W 8
`define ASBP_CYCLES_MIN(ns) \
	(((ns) + `ASBP_CLK_PERIOD_NS - 1) / `ASBP_CLK_PERIOD_NS)
`endif

// >>> rtl/asbp_pkg.sv
// Types shared by the async SRAM byte port controller
package asbp_pkg;
	typedef struct packed
	{
		logic write;
		logic [18:0] addr;
		logic [7:0] wdata;
	} asbp_req_type;

	typedef struct packed
	{
		logic chip_select_n;
		logic output_enable_n;
		logic write_enable_n;
	} asbp_ctl_type;

	typedef enum logic [4:0]
	{
		ASBP_POWERUP = 5'b0_0001,
		ASBP_IDLE = 5'b0_0010,
		ASBP_READ = 5'b0_0100,
		ASBP_WRITE = 5'b0_1000,
		ASBP_RECOVER = 5'b1_0000
	} asbp_state_type;
endpackage

// >>> rtl/asbp_timer.sv
// Down counter used to hold each read or write strobe for a fixed cycle count
module asbp_timer #(
	parameter int WIDTH = 8
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic load,
	input wire logic [WIDTH-1:0] count,
	output logic done
);
	logic [WIDTH-1:0] count_r;

	// Load on request, otherwise count down to zero
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			count_r <= '0;
		else if (load)
			count_r <= count;
		else if (count_r != '0)
			count_r <= count_r - 1'b1;
	end

	assign done = (count_r == '0) && !load;
endmodule

// >>> rtl/asbp_ctrl.sv
// Host controller driving an asynchronous 512K x 8 static RAM
`include "asbp_consts.svh"
module asbp_ctrl #(
	parameter int POWERUP_CYCLES =
		`ASBP_CYCLES_MIN(`ASBP_POWERUP_WAIT_NS)
) (
	input wire logic clock,
	input wire logic resetn,
	input wire asbp_pkg::asbp_req_type req,
	input wire logic req_valid,
	output logic req_ready,
	output logic [7:0] rdata,
	output logic rdata_valid,
	output logic [18:0] address_lines,
	output asbp_pkg::asbp_ctl_type ctl,
	input wire logic [7:0] data_lines_in,
	output logic [7:0] data_lines_out,
	output logic data_lines_oe
);
	import asbp_pkg::*;

	// Read strobe covers read cycle and select-to-data time
	localparam int RD_CYC = `ASBP_CYCLES_MIN(
		`ASBP_READ_CYCLE_MIN_NS > `ASBP_SELECT_TO_DATA_VALID_NS ?
		`ASBP_READ_CYCLE_MIN_NS : `ASBP_SELECT_TO_DATA_VALID_NS);
	// Write strobe covers release plus set-up, and the pulse minimum
	localparam int WR_NS = `ASBP_WRITE_LOW_TO_RELEASE_NS +
		`ASBP_WRITE_DATA_SETUP_NS;
	localparam int WR_CYC = `ASBP_CYCLES_MIN(
		WR_NS > `ASBP_WRITE_PULSE_MIN_NS ?
		WR_NS : `ASBP_WRITE_PULSE_MIN_NS);
	// Timer load is one less than the strobe length in cycles
	localparam int CNT_W = `ASBP_CNT_W;
	localparam logic [CNT_W-1:0] RD_LOAD = CNT_W'(RD_CYC - 1);
	localparam logic [CNT_W-1:0] WR_LOAD = CNT_W'(WR_CYC - 1);
	// Power-up counter sized to hold its load
	localparam int PU_W = $clog2(POWERUP_CYCLES + 1);
	localparam logic [PU_W-1:0] PU_LOAD = PU_W'(POWERUP_CYCLES);

	asbp_state_type state_r;
	asbp_state_type state_nxt;
	logic [PU_W-1:0] pu_cnt_r;
	logic [7:0] sync1_r;
	logic [7:0] sync2_r;
	logic timer_load;
	logic [`ASBP_CNT_W-1:0] timer_count;
	logic timer_done;
	logic take;
	// Read tracking across the recover cycle
	logic rd_pend_r;
	logic rd_cap_r;

	// Phase timer for read and write pulses
	// A zero load still gives one strobe cycle
	asbp_timer #(
		.WIDTH(`ASBP_CNT_W)
	) u_timer (
		.clock(clock),
		.resetn(resetn),
		.load(timer_load),
		.count(timer_count),
		.done(timer_done)
	);

	// Power-up wait before first access
	// Requests are refused until this reaches zero
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			pu_cnt_r <= PU_LOAD;
		else if (pu_cnt_r != '0)
			pu_cnt_r <= pu_cnt_r - 1'b1;
	end

	// Ready only in idle; a take starts the access
	assign req_ready = (state_r == ASBP_IDLE);
	assign take = req_ready && req_valid;
	// Each take restarts the phase timer
	assign timer_load = take;
	assign timer_count = req.write ? WR_LOAD : RD_LOAD;

	// Access sequencing
	// Recover cycle keeps strobes at least a read cycle apart
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			ASBP_POWERUP:
				if (pu_cnt_r == '0)
					state_nxt = ASBP_IDLE;
			ASBP_IDLE:
				if (take)
					state_nxt = req.write ? ASBP_WRITE : ASBP_READ;
			ASBP_READ:
				if (timer_done)
					state_nxt = ASBP_RECOVER;
			ASBP_WRITE:
				if (timer_done)
					state_nxt = ASBP_RECOVER;
			ASBP_RECOVER:
				state_nxt = ASBP_IDLE;
			default:
				state_nxt = ASBP_POWERUP;
		endcase
	end

	// State register
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			state_r <= ASBP_POWERUP;
		else
			state_r <= state_nxt;
	end

	// Address and write data held for the whole access
	// Held until the next take, steady through the strobe
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			address_lines <= '0;
			data_lines_out <= '0;
		end
		else if (take)
		begin
			address_lines <= req.addr;
			data_lines_out <= req.wdata;
		end
	end

	// Pin controls; write ends by raising enable and select together
	// Joint rise keeps the device from driving after a write
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			ctl <= '{1'b1, 1'b1, 1'b1};
			data_lines_oe <= 1'b0;
		end
		else
		begin
			ctl.chip_select_n <= !(state_nxt == ASBP_READ ||
				state_nxt == ASBP_WRITE);
			ctl.output_enable_n <= !(state_nxt == ASBP_READ);
			ctl.write_enable_n <= !(state_nxt == ASBP_WRITE);
			// Drive only in write, OE held high so device floats
			data_lines_oe <= (state_nxt == ASBP_WRITE);
		end
	end

	// Data pins pass two flip-flops before use
	// Only sync2_r reads sync1_r
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
		end
		else
		begin
			sync1_r <= data_lines_in;
			sync2_r <= sync1_r;
		end
	end

	// Read strobe ended last edge; byte reaches sync2_r at this one
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			rd_cap_r <= 1'b0;
		else
			rd_cap_r <= (state_r == ASBP_RECOVER) && rd_pend_r;
	end

	// Capture read byte once it has passed both flip-flops
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			rdata <= '0;
			rdata_valid <= 1'b0;
		end
		else
		begin
			rdata_valid <= rd_cap_r;
			if (rd_cap_r)
				rdata <= sync2_r;
		end
	end

	// Remembers that the current access is a read
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			rd_pend_r <= 1'b0;
		else if (take)
			rd_pend_r <= !req.write;
	end
endmodule

// >>> bench/asbp_sram_model.sv
// Behavioural static RAM on the controller's pins
module asbp_sram_model (
	input wire asbp_pkg::asbp_ctl_type ctl,
	input wire logic [18:0] address_lines,
	input wire logic [7:0] data_lines_out,
	output logic [7:0] data_lines_in
);
	timeunit 1ns;
	timeprecision 1ns;
	import asbp_pkg::*;
	logic [7:0] mem [logic [18:0]];
	logic wr_on_r = 1'b0;
	logic [7:0] last_r = 8'h00;
	logic rd;
	assign rd = !ctl.chip_select_n && !ctl.output_enable_n &&
		ctl.write_enable_n;
	// Store when the select/write overlap ends, on either rising edge
	always @(ctl)
	begin
		if (wr_on_r && (ctl.chip_select_n || ctl.write_enable_n))
			mem[address_lines] = data_lines_out;
		wr_on_r = !ctl.chip_select_n && !ctl.write_enable_n;
	end
	// Fetch the addressed byte in read mode
	always @*
		if (rd)
			last_r = mem[address_lines];
	// Released lines show a stale inverse
	assign data_lines_in = rd ? last_r : ~last_r;
endmodule

// >>> bench/asbp_ctrl_props.sv
// Pin and handshake timing checks for the controller
module asbp_ctrl_props #(
	parameter int POWERUP_CYCLES = 2
) (
	input wire logic clock,
	input wire logic resetn,
	input wire asbp_pkg::asbp_req_type req,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic rdata_valid,
	input wire logic [18:0] address_lines,
	input wire asbp_pkg::asbp_ctl_type ctl,
	input wire logic [7:0] data_lines_out,
	input wire logic data_lines_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	import asbp_pkg::*;
	logic [7:0] up_r;
	logic take;
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	assign take = req_valid && req_ready;
	// Cycles since reset release, saturating
	always_ff @(posedge clock or negedge resetn)
		if (!resetn)
			up_r <= 8'h00;
		else if (up_r != 8'hFF)
			up_r <= up_r + 8'h01;
	power_wait_a: assert property (up_r < POWERUP_CYCLES |->
		!req_ready && ctl.chip_select_n) else $error("early access");
	idle_quiet_a: assert property (req_ready |->
		ctl == 3'h7 && !data_lines_oe) else $error("idle not quiet");
	take_addr_a: assert property (take |=>
		!ctl.chip_select_n && address_lines == $past(req.addr))
		else $error("bad select or address");
	read_mode_a: assert property (take && !req.write |=>
		!ctl.output_enable_n && ctl.write_enable_n && !data_lines_oe)
		else $error("bad read pins");
	write_mode_a: assert property (take && req.write |=>
		!ctl.write_enable_n && ctl.output_enable_n && data_lines_oe &&
		data_lines_out == $past(req.wdata)) else $error("bad write pins");
	spacing_a: assert property ($fell(ctl.chip_select_n) |=>
		ctl.chip_select_n [*2]) else $error("bad strobe length");
	joint_end_a: assert property ($rose(ctl.write_enable_n) |->
		$rose(ctl.chip_select_n)) else $error("write end split");
	read_done_a: assert property (take && !req.write |->
		##4 rdata_valid) else $error("no read answer");
endmodule

// >>> bench/testbench.sv
// Self-checking bench for the byte port controller
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import asbp_pkg::*;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	asbp_req_type req = '0;
	logic req_valid = 1'b0;
	logic req_ready, rdata_valid, data_lines_oe;
	logic [7:0] rdata, data_lines_out, data_lines_in;
	logic [18:0] address_lines;
	asbp_ctl_type ctl;
	logic [7:0] exp_q [$];
	logic [7:0] shadow [logic [18:0]];
	logic [18:0] adr [10];
	int err_total = 0;
	int checks_done = 0;
	// Clock at 50 ns
	always #25 clock = ~clock;
	asbp_ctrl #(.POWERUP_CYCLES(2)) u_dut (.clock, .resetn, .req,
		.req_valid, .req_ready, .rdata, .rdata_valid, .address_lines,
		.ctl, .data_lines_in, .data_lines_out, .data_lines_oe);
	asbp_sram_model u_mem (.ctl, .address_lines, .data_lines_out,
		.data_lines_in);
	// Hold a request until taken, note read data
	task automatic xfer(logic w, logic [18:0] a, logic [7:0] d);
		int n;
		n = 0;
		req <= '{w, a, d};
		req_valid <= 1'b1;
		do @(posedge clock); while (req_ready !== 1'b1 && ++n < 40);
		if (n >= 40)
		begin
			err_total++;
			$display("mismatch req_ready exp 1 got %b", req_ready);
		end
		if (!w)
			exp_q.push_back(d);
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Compare each returned byte with the oldest note
	always @(posedge clock)
		if (rdata_valid === 1'b1)
		begin
			checks_done++;
			if (exp_q.size() == 0 || rdata !== exp_q[0])
			begin
				err_total++;
				$display("mismatch rdata exp %h got %h", exp_q[0], rdata);
			end
			if (exp_q.size() != 0)
				void'(exp_q.pop_front());
		end
	// Writes incl. end addresses, overwrite, read back
	initial
	begin
		void'($urandom(32'h4278));
		repeat (10) @(posedge clock);
		resetn <= 1'b1;
		for (int i = 0; i < 10; i++)
		begin
			adr[i] = i == 8 ? 19'h0_0000 : i == 9 ? 19'h7_FFFF : 19'($urandom);
			shadow[adr[i]] = 8'($urandom);
			xfer(1'b1, adr[i], shadow[adr[i]]);
		end
		shadow[adr[0]] = ~shadow[adr[0]];
		xfer(1'b1, adr[0], shadow[adr[0]]);
		foreach (adr[i])
			xfer(1'b0, adr[i], shadow[adr[i]]);
		req_valid <= 1'b0;
		repeat (6) @(posedge clock);
		if (exp_q.size() != 0)
		begin
			err_total++;
			$display("mismatch pending exp 0 got %0d", exp_q.size());
		end
		wrap_up;
	end
	// Watchdog against a hang
	initial
	begin
		#100us;
		err_total++;
		wrap_up;
	end
endmodule
bind asbp_ctrl asbp_ctrl_props #(.POWERUP_CYCLES(POWERUP_CYCLES)) u_props (
	.clock, .resetn, .req, .req_valid, .req_ready, .rdata_valid,
	.address_lines, .ctl, .data_lines_out, .data_lines_oe);
